// ---- pmsmi_phy.sv ----
`timescale 1ns/1ps
`include "pmsmi_defines.svh"

// =====================================================================
// two-flop synchroniser plus one history stage for edge finding
module pmsmi_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q,
  output logic [W-1:0] q_prev
);
  logic [W-1:0] s1;

  // stage one feeds only stage two
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s1 <= '0;
      q <= '0;
      q_prev <= '0;
    end else begin
      s1 <= d;
      q <= s1;
      q_prev <= q;
    end
  end
endmodule : pmsmi_sync

// =====================================================================
// synchronous fifo
module pmsmi_fifo #(
  parameter int W = `PMSMI_WORD_W,
  parameter int D = `PMSMI_FIFO_DEPTH
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // fill side
  input wire logic [W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // drain side
  output logic [W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;
  logic [AW:0] next_count;

  // flags are registered so ready is clean toward the source
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_data = mem[rd_ptr];
  assign next_count = count + (AW+1)'(push) - (AW+1)'(pop);

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      wr_ptr <= push ? AW'(wr_ptr + 1'b1) : wr_ptr;
      rd_ptr <= pop ? AW'(rd_ptr + 1'b1) : rd_ptr;
      count <= next_count;
      in_ready <= next_count < (AW+1)'(D);
      out_valid <= next_count != '0;
    end
  end
endmodule : pmsmi_fifo

// =====================================================================
// physical-layer end of the media interface
module pmsmi_phy
  import pmsmi_pkg::*;
#(
  parameter logic [7:0] HALF_10 = 8'(`PMSMI_HALF(`PMSMI_RATE_10_KHZ)),
  parameter logic [7:0] HALF_100 = 8'(`PMSMI_HALF(`PMSMI_RATE_100_KHZ)),
  parameter logic [7:0] HALF_1000 = 8'(`PMSMI_HALF(`PMSMI_RATE_1000_KHZ))
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // configuration
  input wire pmsmi_mode_t mode,
  input wire pmsmi_speed_t speed,
  // link toward the mac
  pmsmi_if.phy link,
  // transmit symbols toward the line coder
  output logic [7:0] tx_line_data,
  output pmsmi_sym_t tx_line_sym,
  output logic tx_line_nibble,
  output logic tx_line_valid,
  // receive bytes from the line decoder
  input wire logic [7:0] rx_in_data,
  input wire logic rx_in_err,
  input wire logic rx_in_last,
  input wire logic rx_in_valid,
  output logic rx_in_ready
);
  logic [7:0] half;
  logic [7:0] cnt;
  logic tog;
  logic gen_rise;
  logic gen_fall;
  logic g_q;
  logic g_qp;
  logic [`PMSMI_WORD_W-1:0] t_q;
  logic [`PMSMI_WORD_W-1:0] t_qp;
  logic gtx_rise;
  logic gtx_fall;
  logic [`PMSMI_WORD_W-1:0] f_data;
  logic f_valid;
  logic f_pop;
  logic rx_ph;
  logic rx_gap;
  logic [7:0] rx_cur;
  logic rx_cur_vld;
  logic rx_cur_err;
  logic [3:0] tx_lo;
  logic tx_ctl_r;
  pmsmi_txerr_t te_state;
  pmsmi_txerr_t next_te;

  // one divider makes both link clocks; they run in every mode
  assign half = pmsmi_half(speed, HALF_10, HALF_100, HALF_1000);
  assign tog = cnt == 8'(half - 8'h01);
  assign gen_rise = tog & ~link.rx_clk;
  assign gen_fall = tog & link.rx_clk;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= '0;
      link.rx_clk <= 1'b0;
      link.tx_clk <= 1'b0;
    end else begin
      cnt <= tog ? 8'h00 : 8'(cnt + 8'h01);
      if (tog) begin
        link.rx_clk <= ~link.rx_clk;
        link.tx_clk <= ~link.rx_clk;
      end
    end
  end

  // =====================================================================
  // receive path: fifo drained at the link beat
  pmsmi_fifo #(.W(`PMSMI_WORD_W), .D(`PMSMI_FIFO_DEPTH)) u_rx_fifo (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .in_data({rx_in_last, rx_in_err, rx_in_data}),
    .in_valid(rx_in_valid),
    .in_ready(rx_in_ready),
    .out_data(f_data),
    .out_valid(f_valid),
    .out_ready(f_pop)
  );

  // a byte is taken only on a falling toggle with no nibble pending
  assign f_pop = gen_fall & f_valid & ~rx_gap & ~(mode == PMSMI_MODE_MII && rx_ph);

  // data changes at our falling edge, and in rgmii also at the rising edge, so the mac samples it mid-bit
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      link.rxd <= 8'h00;
      link.rx_dv_ctrl <= 1'b0;
      link.rx_er <= 1'b0;
      rx_ph <= 1'b0;
      rx_gap <= 1'b0;
      rx_cur <= 8'h00;
      rx_cur_vld <= 1'b0;
      rx_cur_err <= 1'b0;
    end else if (gen_fall) begin
      if (mode == PMSMI_MODE_MII && rx_ph) begin
        link.rxd <= {4'h0, rx_cur[7:4]};
        rx_ph <= 1'b0;
      end else if (f_pop) begin
        rx_cur <= f_data[7:0];
        rx_cur_vld <= 1'b1;
        rx_cur_err <= f_data[`PMSMI_WORD_ERR];
        rx_gap <= f_data[`PMSMI_WORD_LAST];
        link.rx_dv_ctrl <= 1'b1;
        link.rx_er <= (mode != PMSMI_MODE_RGMII) & f_data[`PMSMI_WORD_ERR];
        rx_ph <= mode == PMSMI_MODE_MII;
        link.rxd <= (mode == PMSMI_MODE_GMII) ? f_data[7:0] : {4'h0, f_data[3:0]};
      end else begin
        // idle beat; a frame end forces one idle beat before the next
        rx_gap <= 1'b0;
        rx_cur_vld <= 1'b0;
        rx_cur_err <= 1'b0;
        link.rx_dv_ctrl <= 1'b0;
        link.rx_er <= 1'b0;
        link.rxd <= 8'h00;
      end
    end else if (gen_rise && mode == PMSMI_MODE_RGMII) begin
      // high nibble before the falling edge
      link.rxd <= {4'h0, rx_cur[7:4]};
      // second half is valid xor error
      link.rx_dv_ctrl <= rx_cur_vld ^ rx_cur_err;
    end
  end

  // =====================================================================
  // transmit path: mac pins pass two flops first
  pmsmi_sync #(.W(1)) u_gtx_sync (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .d(link.gtx_clk),
    .q(g_q),
    .q_prev(g_qp)
  );

  pmsmi_sync #(.W(`PMSMI_WORD_W)) u_tx_sync (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .d({link.tx_er, link.tx_en_ctrl, link.txd}),
    .q(t_q),
    .q_prev(t_qp)
  );

  // history stage holds the bus as it stood just before the edge
  assign gtx_rise = g_q & ~g_qp;
  assign gtx_fall = ~g_q & g_qp;

  // error nibbles: one invalid, then halt until released
  always_comb begin
    if (!t_q[`PMSMI_BIT_CTL] || !t_q[`PMSMI_BIT_ERR]) begin
      next_te = PMSMI_TE_DATA;
    end else begin
      case (te_state)
        PMSMI_TE_DATA: next_te = PMSMI_TE_INVALID;
        PMSMI_TE_INVALID: next_te = PMSMI_TE_HALT;
        PMSMI_TE_HALT: next_te = PMSMI_TE_HALT;
        default: next_te = PMSMI_TE_DATA;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      te_state <= PMSMI_TE_DATA;
    end else if (gen_rise && mode == PMSMI_MODE_MII) begin
      te_state <= next_te;
    end
  end

  // sample transmit data on its clock
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_line_data <= 8'h00;
      tx_line_sym <= PMSMI_SYM_IDLE;
      tx_line_nibble <= 1'b0;
      tx_line_valid <= 1'b0;
      tx_lo <= 4'h0;
      tx_ctl_r <= 1'b0;
    end else begin
      tx_line_valid <= 1'b0;
      case (mode)
        PMSMI_MODE_MII: begin
          // our own tx_clk rising; mac drove after the previous one
          if (gen_rise && t_q[`PMSMI_BIT_CTL]) begin
            tx_line_valid <= 1'b1;
            tx_line_nibble <= 1'b1;
            tx_line_data <= {4'h0, t_q[3:0]};
            case (next_te)
              PMSMI_TE_INVALID: tx_line_sym <= PMSMI_SYM_INVALID;
              PMSMI_TE_HALT: tx_line_sym <= PMSMI_SYM_HALT;
              default: tx_line_sym <= PMSMI_SYM_DATA;
            endcase
          end
        end
        PMSMI_MODE_GMII: begin
          // error byte becomes an invalid code-group
          if (gtx_rise && t_qp[`PMSMI_BIT_CTL]) begin
            tx_line_valid <= 1'b1;
            tx_line_nibble <= 1'b0;
            tx_line_data <= t_qp[7:0];
            tx_line_sym <= t_qp[`PMSMI_BIT_ERR] ? PMSMI_SYM_INVALID : PMSMI_SYM_DATA;
          end
        end
        default: begin
          if (gtx_rise) begin
            tx_lo <= t_qp[3:0];
            tx_ctl_r <= t_qp[`PMSMI_BIT_CTL];
          end else if (gtx_fall && tx_ctl_r) begin
            tx_line_valid <= 1'b1;
            tx_line_nibble <= 1'b0;
            tx_line_data <= {t_qp[3:0], tx_lo};
            tx_line_sym <= (tx_ctl_r ^ t_qp[`PMSMI_BIT_CTL]) ? PMSMI_SYM_INVALID
                                                               : PMSMI_SYM_DATA;
          end
        end
      endcase
    end
  end
endmodule : pmsmi_phy

// ---- pmsmi_defines.svh ----
`ifndef PMSMI_DEFINES_SVH
`define PMSMI_DEFINES_SVH

// =====================================================================
// clock rates and derived divider counts
`define PMSMI_SYS_CLK_KHZ 20000
`define PMSMI_RATE_10_KHZ 2500
`define PMSMI_RATE_100_KHZ 25000
`define PMSMI_RATE_1000_KHZ 125000
// floor on the half period: the MII transmit round trip needs 6 cycles
`define PMSMI_HALF_MIN 4
// half period in sys_clk cycles, rounded down, never under the floor
`define PMSMI_HALF(khz) ((`PMSMI_SYS_CLK_KHZ / (2 * (khz))) > `PMSMI_HALF_MIN ? \
  (`PMSMI_SYS_CLK_KHZ / (2 * (khz))) : `PMSMI_HALF_MIN)

// =====================================================================
// widths and word layouts
`define PMSMI_CNT_W 8
`define PMSMI_FIFO_DEPTH 16
`define PMSMI_WORD_W 10
// pin bundle and fifo word: [7:0] data, [8] enable or error, [9] error or last
`define PMSMI_BIT_CTL 8
`define PMSMI_BIT_ERR 9
`define PMSMI_WORD_ERR 8
`define PMSMI_WORD_LAST 9

`endif

// ---- pmsmi_pkg.sv ----
package pmsmi_pkg;

  // =====================================================================
  // interface mode and line speed
  typedef enum logic [1:0] {
    PMSMI_MODE_MII = 2'h0,
    PMSMI_MODE_GMII = 2'h1,
    PMSMI_MODE_RGMII = 2'h3
  } pmsmi_mode_t;

  typedef enum logic [1:0] {
    PMSMI_SPD_10 = 2'h0,
    PMSMI_SPD_100 = 2'h1,
    PMSMI_SPD_1000 = 2'h2
  } pmsmi_speed_t;

  // symbol class handed to the line coder
  typedef enum logic [1:0] {
    PMSMI_SYM_IDLE = 2'h0,
    PMSMI_SYM_DATA = 2'h1,
    PMSMI_SYM_INVALID = 2'h2,
    PMSMI_SYM_HALT = 2'h3
  } pmsmi_sym_t;

  // nibble-mode transmit error sequence, gray along data-invalid-halt
  typedef enum logic [1:0] {
    PMSMI_TE_DATA = 2'h0,
    PMSMI_TE_INVALID = 2'h1,
    PMSMI_TE_HALT = 2'h3
  } pmsmi_txerr_t;

  // half period for the selected speed
  function automatic logic [7:0] pmsmi_half(input pmsmi_speed_t spd,
                                            input logic [7:0] h10,
                                            input logic [7:0] h100,
                                            input logic [7:0] h1000);
    case (spd)
      PMSMI_SPD_10: pmsmi_half = h10;
      PMSMI_SPD_100: pmsmi_half = h100;
      default: pmsmi_half = h1000;
    endcase
  endfunction : pmsmi_half

endpackage : pmsmi_pkg

// ---- pmsmi_if.sv ----
`timescale 1ns/1ps
interface pmsmi_if;
  // transmit path, mac to phy
  logic gtx_clk;
  logic tx_clk;
  logic [7:0] txd;
  logic tx_en_ctrl;
  logic tx_er;
  // receive path, phy to mac
  logic rx_clk;
  logic [7:0] rxd;
  logic rx_dv_ctrl;
  logic rx_er;

  modport phy (
    input gtx_clk, txd, tx_en_ctrl, tx_er,
    output tx_clk, rx_clk, rxd, rx_dv_ctrl, rx_er
  );

  modport mac (
    output gtx_clk, txd, tx_en_ctrl, tx_er,
    input tx_clk, rx_clk, rxd, rx_dv_ctrl, rx_er
  );
endinterface : pmsmi_if

// ---- pmsmi_mac.sv ----
`timescale 1ns/1ps
`include "pmsmi_defines.svh"

// =====================================================================
// media access controller end of the media interface
module pmsmi_mac
  import pmsmi_pkg::*;
#(
  parameter logic [7:0] HALF_1000 = 8'(`PMSMI_HALF(`PMSMI_RATE_1000_KHZ))
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // configuration
  input wire pmsmi_mode_t mode,
  // link toward the phy
  pmsmi_if.mac link,
  // transmit bytes from the user
  input wire logic [7:0] tx_data,
  input wire logic tx_err,
  input wire logic tx_valid,
  output logic tx_ready,
  // receive bytes toward the user
  output logic [7:0] rx_data,
  output logic rx_err,
  output logic rx_valid,
  output logic rx_frame
);
  logic [7:0] cnt;
  logic tog;
  logic gen_rise;
  logic gen_fall;
  logic c_q;
  logic c_qp;
  logic txc_rise;
  logic [7:0] tb_data;
  logic tb_err;
  logic tb_full;
  logic take;
  logic load;
  logic next_full;
  logic tx_ph;
  logic [7:0] cur;
  logic cur_en;
  logic cur_err;
  logic r_q;
  logic r_qp;
  logic [`PMSMI_WORD_W-1:0] d_q;
  logic [`PMSMI_WORD_W-1:0] d_qp;
  logic rxc_rise;
  logic rxc_fall;
  logic [3:0] rx_lo;
  logic rx_ph;
  logic ctl_r;

  // gtx_clk runs free from reset on
  assign tog = cnt == 8'(HALF_1000 - 8'h01);
  assign gen_rise = tog & ~link.gtx_clk;
  assign gen_fall = tog & link.gtx_clk;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= '0;
      link.gtx_clk <= 1'b0;
    end else begin
      cnt <= tog ? 8'h00 : 8'(cnt + 8'h01);
      if (tog) begin
        link.gtx_clk <= ~link.gtx_clk;
      end
    end
  end

  // =====================================================================
  // transmit: one-byte holding stage, ready registered
  pmsmi_sync #(.W(1)) u_txc_sync (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .d(link.tx_clk),
    .q(c_q),
    .q_prev(c_qp)
  );

  assign txc_rise = c_q & ~c_qp;
  assign take = tx_valid & tx_ready;
  assign load = (mode == PMSMI_MODE_MII) ? (txc_rise & ~tx_ph) : gen_fall;
  assign next_full = (tb_full & ~load) | take;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      tb_data <= 8'h00;
      tb_err <= 1'b0;
      tb_full <= 1'b0;
      tx_ready <= 1'b0;
    end else begin
      if (take) begin
        tb_data <= tx_data;
        tb_err <= tx_err;
      end
      tb_full <= next_full;
      tx_ready <= ~next_full;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      link.txd <= 8'h00;
      link.tx_en_ctrl <= 1'b0;
      link.tx_er <= 1'b0;
      tx_ph <= 1'b0;
      cur <= 8'h00;
      cur_en <= 1'b0;
      cur_err <= 1'b0;
    end else if (load) begin
      cur <= tb_data;
      cur_en <= tb_full;
      cur_err <= tb_full & tb_err;
      link.tx_en_ctrl <= tb_full;
      link.tx_er <= tb_full & tb_err & (mode != PMSMI_MODE_RGMII);
      tx_ph <= tb_full & (mode == PMSMI_MODE_MII);
      if (!tb_full) begin
        link.txd <= 8'h00;
      end else if (mode == PMSMI_MODE_GMII) begin
        link.txd <= tb_data;
      end else begin
        link.txd <= {4'h0, tb_data[3:0]};
      end
    end else if (mode == PMSMI_MODE_MII && txc_rise && tx_ph) begin
      link.txd <= {4'h0, cur[7:4]};
      tx_ph <= 1'b0;
    end else if (mode == PMSMI_MODE_RGMII && gen_rise) begin
      // second half is enable xor error
      link.txd <= {4'h0, cur[7:4]};
      link.tx_en_ctrl <= cur_en ^ cur_err;
    end
  end

  // =====================================================================
  // receive: sample the bus as it stood just before each edge
  pmsmi_sync #(.W(1)) u_rxc_sync (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .d(link.rx_clk),
    .q(r_q),
    .q_prev(r_qp)
  );

  pmsmi_sync #(.W(`PMSMI_WORD_W)) u_rxd_sync (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .d({link.rx_er, link.rx_dv_ctrl, link.rxd}),
    .q(d_q),
    .q_prev(d_qp)
  );

  assign rxc_rise = r_q & ~r_qp;
  assign rxc_fall = ~r_q & r_qp;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_data <= 8'h00;
      rx_err <= 1'b0;
      rx_valid <= 1'b0;
      rx_frame <= 1'b0;
      rx_lo <= 4'h0;
      rx_ph <= 1'b0;
      ctl_r <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      if (rxc_rise) begin
        rx_frame <= d_qp[`PMSMI_BIT_CTL];
        ctl_r <= d_qp[`PMSMI_BIT_CTL];
        rx_lo <= d_qp[3:0];
        rx_ph <= d_qp[`PMSMI_BIT_CTL] & (mode == PMSMI_MODE_MII) & ~rx_ph;
        if (mode == PMSMI_MODE_GMII && d_qp[`PMSMI_BIT_CTL]) begin
          rx_valid <= 1'b1;
          rx_data <= d_qp[7:0];
          rx_err <= d_qp[`PMSMI_BIT_ERR];
        end else if (mode == PMSMI_MODE_MII && d_qp[`PMSMI_BIT_CTL] && rx_ph) begin
          rx_valid <= 1'b1;
          rx_data <= {d_qp[3:0], rx_lo};
          rx_err <= d_qp[`PMSMI_BIT_ERR];
          rx_lo <= rx_lo;
        end
      end else if (rxc_fall && mode == PMSMI_MODE_RGMII && ctl_r) begin
        rx_valid <= 1'b1;
        rx_data <= {d_qp[3:0], rx_lo};
        rx_err <= ctl_r ^ d_qp[`PMSMI_BIT_CTL];
      end
    end
  end
endmodule : pmsmi_mac

// ---- pmsmi_link_sva.sv ----
`timescale 1ns/1ps
// ==========
// link pin checker, watches the interface joining both ends
module pmsmi_link_sva
  import pmsmi_pkg::*;
(
  // clock, reset and mode
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire pmsmi_mode_t mode,
  // transmit pins
  input wire logic gtx_clk,
  input wire logic tx_clk,
  input wire logic [7:0] txd,
  input wire logic tx_en_ctrl,
  input wire logic tx_er,
  // receive pins
  input wire logic rx_clk,
  input wire logic [7:0] rxd,
  input wire logic rx_dv_ctrl,
  input wire logic rx_er
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  // dividers default to four cycles a half period
  gtx_period_a: assert property ($rose(gtx_clk) |-> gtx_clk [*4] ##1 !gtx_clk)
    else $error("gtx clock half period wrong");
  txc_period_a: assert property ($rose(tx_clk) |-> tx_clk [*4] ##1 !tx_clk)
    else $error("tx clock half period wrong");
  rxc_period_a: assert property ($fell(rx_clk) |-> !rx_clk [*4] ##1 rx_clk)
    else $error("rx clock half period wrong");
  clk_pair_a: assert property (rx_clk == tx_clk)
    else $error("rx and tx clocks apart");
  // gmii transmit and non-rgmii receive data may only move while the sampling clock is low
  gmii_tx_hold_a: assert property (mode == PMSMI_MODE_GMII && gtx_clk |->
      $stable({txd, tx_en_ctrl, tx_er}))
    else $error("gmii transmit pins moved with clock high");
  rx_hold_a: assert property (mode != PMSMI_MODE_RGMII && rx_clk |->
      $stable({rxd, rx_dv_ctrl, rx_er}))
    else $error("receive pins moved with clock high");
  rx_upper_a: assert property (mode != PMSMI_MODE_GMII |-> $stable(rxd[7:4]))
    else $error("upper receive nibble moved outside gmii");
  rgmii_rxer_a: assert property (mode == PMSMI_MODE_RGMII |-> !rx_er)
    else $error("receive error pin used in rgmii");
endmodule : pmsmi_link_sva

// ---- testbench.sv ----
`timescale 1ns/1ps
module testbench;
  import pmsmi_pkg::*;
  // ==========
  // signals and scoreboards
  logic sys_clk, rst_b, full, fseen;
  pmsmi_mode_t mode;
  pmsmi_speed_t speed;
  logic [7:0] tx_data, rx_in_data, tl_data, rx_data;
  logic tx_err, tx_valid, tx_ready, rx_in_err, rx_in_last, rx_in_valid, rx_in_ready;
  pmsmi_sym_t tl_sym;
  logic tl_nib, tl_vld, rx_err, rx_valid, rx_frame;
  int err_count, cmp_count, seed;
  logic [10:0] tq[$], etq[$];
  logic [8:0] rq[$], erq[$];

  pmsmi_if link_if();
  pmsmi_phy pmsmi_phy_inst (.sys_clk(sys_clk), .rst_b(rst_b), .mode(mode), .speed(speed),
    .link(link_if), .tx_line_data(tl_data), .tx_line_sym(tl_sym), .tx_line_nibble(tl_nib),
    .tx_line_valid(tl_vld), .rx_in_data(rx_in_data), .rx_in_err(rx_in_err),
    .rx_in_last(rx_in_last), .rx_in_valid(rx_in_valid), .rx_in_ready(rx_in_ready));
  pmsmi_mac pmsmi_mac_inst (.sys_clk(sys_clk), .rst_b(rst_b), .mode(mode), .link(link_if),
    .tx_data(tx_data), .tx_err(tx_err), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .rx_data(rx_data), .rx_err(rx_err), .rx_valid(rx_valid), .rx_frame(rx_frame));
  pmsmi_link_sva pmsmi_link_sva_inst (.sys_clk(sys_clk), .rst_b(rst_b), .mode(mode),
    .gtx_clk(link_if.gtx_clk), .tx_clk(link_if.tx_clk), .txd(link_if.txd),
    .tx_en_ctrl(link_if.tx_en_ctrl), .tx_er(link_if.tx_er), .rx_clk(link_if.rx_clk),
    .rxd(link_if.rxd), .rx_dv_ctrl(link_if.rx_dv_ctrl), .rx_er(link_if.rx_er));

  // ==========
  // clock and output capture; data bits of error symbols are not defined
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // sampled mid-cycle so a one-cycle pulse is read once, after it settles
  always @(negedge sys_clk) begin
    if (tl_vld === 1'b1)
      tq.push_back({tl_nib, tl_sym, tl_data &
        (tl_sym == PMSMI_SYM_DATA ? (tl_nib ? 8'h0f : 8'hff) : 8'h00)});
    if (rx_valid === 1'b1)
      rq.push_back({rx_err, rx_data});
    if (rx_in_ready === 1'b0 && rx_in_valid)
      full = 1'b1;
    if (rx_frame === 1'b1)
      fseen = 1'b1;
  end

  // ==========
  // verdict and comparisons
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : tally_and_finish
  task automatic cmp_sym(input logic [10:0] g, input logic [10:0] e);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %0t symbol got %h expected %h", $time, g, e);
    end
  endtask : cmp_sym
  task automatic cmp_byte(input logic [8:0] g, input logic [8:0] e);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %0t byte got %h expected %h", $time, g, e);
    end
  endtask : cmp_byte

  // ==========
  // line symbols expected for one byte: mii splits it, an error goes invalid then halt in mii, invalid alone otherwise
  function automatic void exp_tx(input logic [7:0] d, input logic e);
    pmsmi_sym_t s;
    s = e ? PMSMI_SYM_INVALID : PMSMI_SYM_DATA;
    if (mode == PMSMI_MODE_MII) begin
      etq.push_back({1'b1, s, e ? 8'h00 : {4'h0, d[3:0]}});
      etq.push_back({1'b1, e ? PMSMI_SYM_HALT : s, e ? 8'h00 : {4'h0, d[7:4]}});
    end else begin
      etq.push_back({1'b0, s, e ? 8'h00 : d});
    end
  endfunction : exp_tx

  // bounded wait for ready on either stream
  task automatic take(input bit rxs);
    int w;
    w = 0;
    do begin
      @(posedge sys_clk);
      w++;
    end while ((rxs ? rx_in_ready : tx_ready) !== 1'b1 && w < 400);
    if ((rxs ? rx_in_ready : tx_ready) !== 1'b1) begin
      err_count++;
      $display("[FAIL] %0t handshake stuck", $time);
      tally_and_finish();
    end
  endtask : take

  // frame from the mac user; a byte is held until taken
  task automatic send_tx(input int len, input int ep);
    logic [7:0] d;
    for (int i = 0; i < len; i++) begin
      d = 8'($random(seed));
      exp_tx(d, i == ep);
      tx_data <= d;
      tx_err <= (i == ep);
      tx_valid <= 1'b1;
      take(1'b0);
    end
    tx_valid <= 1'b0;
  endtask : send_tx

  // frame from the line decoder, fed faster than the link drains it
  task automatic send_rx(input int len, input int ep);
    logic [7:0] d;
    for (int i = 0; i < len; i++) begin
      d = 8'($random(seed));
      erq.push_back({i == ep, d});
      rx_in_data <= d;
      rx_in_err <= (i == ep);
      rx_in_last <= (i == len - 1);
      rx_in_valid <= 1'b1;
      take(1'b1);
    end
    rx_in_valid <= 1'b0;
    rx_in_last <= 1'b0;
  endtask : send_rx

  // wait for both ends to hand everything out, then compare in order
  task automatic check_all();
    int w;
    w = 0;
    while ((tq.size() < etq.size() || rq.size() < erq.size()) && w < 3000) begin
      @(posedge sys_clk);
      w++;
    end
    if (tq.size() < etq.size() || rq.size() < erq.size()) begin
      err_count++;
      $display("[FAIL] %0t link output stuck", $time);
      tally_and_finish();
    end
    cmp_byte(9'(tq.size()), 9'(etq.size()));
    cmp_byte(9'(rq.size()), 9'(erq.size()));
    while (etq.size() && tq.size())
      cmp_sym(tq.pop_front(), etq.pop_front());
    while (erq.size() && rq.size())
      cmp_byte(rq.pop_front(), erq.pop_front());
    tq.delete();
    rq.delete();
    etq.delete();
    erq.delete();
    // frame flag seen during the frame and dropped once the link idles
    repeat (16) @(posedge sys_clk);
    cmp_byte({7'h00, fseen, rx_frame}, 9'h002);
    fseen = 1'b0;
  endtask : check_all

  // ==========
  // each mode in turn from reset, a clean transmit frame then an errored one; both receive frames carry an error
  initial begin
    seed = 22721;
    err_count = 0;
    cmp_count = 0;
    full = 1'b0;
    fseen = 1'b0;
    rst_b = 1'b0;
    mode = PMSMI_MODE_MII;
    speed = PMSMI_SPD_10;
    {tx_data, tx_err, tx_valid} = 10'h000;
    {rx_in_data, rx_in_err, rx_in_last, rx_in_valid} = 11'h000;
    for (int m = 0; m < 3; m++) begin
      mode <= (m == 2) ? PMSMI_MODE_RGMII : pmsmi_mode_t'(m);
      speed <= pmsmi_speed_t'(m);
      rst_b <= 1'b0;
      repeat (12) @(posedge sys_clk);
      rst_b <= 1'b1;
      repeat (2) @(posedge sys_clk);
      full = 1'b0;
      for (int r = 0; r < 2; r++) begin
        fork
          send_tx(3 + int'($unsigned($random(seed)) % 6), r ? 1 : -1);
          send_rx(24, r ? 23 : int'($unsigned($random(seed)) % 24));
        join
        check_all();
      end
      // fifo refused once full
      cmp_byte({8'h00, full}, 9'h001);
      $display("mode %0d done", m);
    end
    tally_and_finish();
  end
endmodule : testbench
